/* verilog/dfp_defines.vh */
// Register map, field layout, reset values and limits for the feedback unit
`ifndef DFP_DEFINES_VH
`define DFP_DEFINES_VH
`define DFP_ADDR_CTRL 12'h000
`define DFP_ADDR_GNA 12'h004
`define DFP_ADDR_GNB 12'h008
`define DFP_ADDR_GDA 12'h00C
`define DFP_ADDR_GDB 12'h010
`define DFP_ADDR_FILT 12'h014
`define DFP_ADDR_PG2 12'h018
`define DFP_ADDR_LOAD_CUM 12'h01C
`define DFP_ADDR_MOT_CUM 12'h020
`define DFP_ADDR_GEARED 12'h024
`define DFP_ADDR_LOAD_INFO 12'h028
`define DFP_ADDR_FBK 12'h02C
`define DFP_ADDR_STATUS 12'h030
`define DFP_ADDR_HOME 12'h034
`define DFP_CTRL_MODE 0
`define DFP_CTRL_POL 1
`define DFP_CTRL_HOME_START 2
`define DFP_CTRL_CLR_CUM 3
`define DFP_FILT_RESET 13'h000A
`define DFP_FILT_SEMI 13'h0000
`define DFP_FILT_FULL 13'h1194
`define DFP_GEAR_RESET 16'h0001
`define DFP_PG2_RESET 16'h0000
`endif

/* verilog/dfp_gear_scale.v */
// Electronic gear: motor count times (na*nb) divided by (da*db)
`timescale 1ns/10ps
`default_nettype none
module dfp_gear_scale (
  input wire pclk, // Clock
  input wire presetn, // Async reset, active low
  input wire clk_en, // Clock enable
  input wire [31:0] motor_cum, // Motor cumulative count
  input wire [15:0] num_a, // gear_numerator_a
  input wire [15:0] num_b, // gear_numerator_b
  input wire [15:0] den_a, // gear_denominator_a
  input wire [15:0] den_b, // gear_denominator_b
  output reg [31:0] geared // Geared motor count
);
  reg [63:0] prod;
  reg [31:0] num;
  reg [31:0] den;
  wire [63:0] quot;
  wire prod_neg;
  wire [63:0] prod_mag;
  assign prod_neg = prod[63];
  assign prod_mag = prod_neg ? (~prod + 64'h0000000000000001) : prod;
  // Zero denominator is clamped to one to keep the division defined
  assign quot = prod_mag / ((den == 32'h00000000) ? 64'h0000000000000001
                                                 : {32'h00000000, den});
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prod <= 64'h0000000000000000;
      num <= 32'h00000001;
      den <= 32'h00000001;
      geared <= 32'h00000000;
    end else if (clk_en) begin
      num <= num_a * num_b;
      den <= den_a * den_b;
      prod <= $signed({{32{motor_cum[31]}}, motor_cum}) *
              $signed({32'h00000000, num});
      geared <= prod_neg ? (~quot[31:0] + 32'h00000001) : quot[31:0];
    end
  end
endmodule
`default_nettype wire

/* verilog/dfp_unit.v */
// Dual feedback position unit: counters, gear, filter blend, home return
//
// Contract
// - In fully closed loop mode the load-side cumulative count follows every load encoder step.
// - Crossing the load-side reference mark or Z-phase clears the load information value to zero.
// - Motor count is scaled by na*nb/(da*db) so it tracks the load count.
// - In fully closed loop mode, filter 0 selects semi closed, 4500 fully closed, 1 to 4499 blended feedback.
// - A larger filter value gives the load-side position more weight.
// - The filter setting is 10 after reset until software writes it.
// - Home return uses only load-side marks and ignores the motor Z-phase.
// - Mode select 0 is semi closed loop, 1 is fully closed loop.
`include "dfp_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module dfp_unit (
  input wire pclk, // APB clock, 10 MHz
  input wire presetn, // Async reset, active low
  input wire clk_en, // Clock enable, freezes state when low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  input wire load_a, // Load encoder phase A pin
  input wire load_b, // Load encoder phase B pin
  input wire load_mark, // Load reference mark or Z-phase pin
  input wire mot_a, // Motor encoder phase A pin
  input wire mot_b, // Motor encoder phase B pin
  input wire dog, // Proximity dog pin
  output reg [31:0] pos_feedback, // Selected position feedback
  output reg home_done, // Home position latched
  output reg home_err // Dog released before mark
);
  reg [2:0] ls_a;
  reg [2:0] ls_b;
  reg [2:0] ls_m;
  reg [2:0] ms_a;
  reg [2:0] ms_b;
  reg [1:0] ds;
  reg mode;
  reg pol;
  reg [15:0] gna;
  reg [15:0] gnb;
  reg [15:0] gda;
  reg [15:0] gdb;
  reg [12:0] filt;
  reg [15:0] pg2;
  reg [31:0] load_cum;
  reg [31:0] mot_cum;
  reg [31:0] load_info;
  reg [31:0] home_pos;
  reg [1:0] hstate;
  reg mark_seen;
  reg dog_prev;
  wire [31:0] geared;
  wire [1:0] ld_step;
  wire [1:0] md_step;
  wire mark_rise;
  wire wr;
  wire rd;
  wire hit;
  wire [12:0] wfilt;
  reg [31:0] rdata;
  reg [31:0] blend;
  reg [45:0] mix;
  reg [45:0] quo;
  localparam H_IDLE = 2'b00;
  localparam H_RUN = 2'b01;
  localparam H_DOGOFF = 2'b10;

  // Quadrature decode: bit1 = step, bit0 = up
  function [1:0] quad;
    input pa;
    input pb;
    input qa;
    input qb;
    begin
      if ((pa ^ qa) && !(pb ^ qb))
        quad = {1'b1, pa ^ pb ^ 1'b1};
      else if ((pb ^ qb) && !(pa ^ qa))
        quad = {1'b1, pa ^ pb};
      else
        quad = 2'b00;
    end
  endfunction

  function [31:0] step_cnt;
    input [31:0] cnt;
    input [1:0] st;
    begin
      if (!st[1])
        step_cnt = cnt;
      else if (st[0])
        step_cnt = cnt + 32'h00000001;
      else
        step_cnt = cnt - 32'h00000001;
    end
  endfunction

  assign ld_step = quad(ls_a[1], ls_b[1], ls_a[2], ls_b[2]);
  assign md_step = quad(ms_a[1], ms_b[1], ms_a[2], ms_b[2]);
  assign mark_rise = ls_m[1] & ~ls_m[2];
  assign wr = psel & penable & pwrite & pready;
  assign rd = psel & ~penable & ~pwrite;
  assign hit = (paddr <= `DFP_ADDR_HOME) && (paddr[1:0] == 2'b00);
  assign wfilt = (pwdata[12:0] > `DFP_FILT_FULL) ? `DFP_FILT_FULL
                                                 : pwdata[12:0];

  dfp_gear_scale u_gear (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .motor_cum(mot_cum),
    .num_a(gna),
    .num_b(gnb),
    .den_a(gda),
    .den_b(gdb),
    .geared(geared)
  );

  // Weighted mix; load weight rises with the filter value
  always @* begin
    mix = $signed({{14{geared[31]}}, geared}) *
            $signed({33'h0, `DFP_FILT_FULL - filt}) +
          $signed({{14{load_cum[31]}}, load_cum}) *
            $signed({33'h0, filt});
    quo = $signed(mix) / $signed({33'h0, `DFP_FILT_FULL});
    if (!mode || filt == `DFP_FILT_SEMI)
      blend = geared;
    else if (filt == `DFP_FILT_FULL)
      blend = load_cum;
    else
      blend = quo[31:0];
  end

  always @* begin
    case (paddr)
      `DFP_ADDR_CTRL: rdata = {30'h0, pol, mode};
      `DFP_ADDR_GNA: rdata = {16'h0000, gna};
      `DFP_ADDR_GNB: rdata = {16'h0000, gnb};
      `DFP_ADDR_GDA: rdata = {16'h0000, gda};
      `DFP_ADDR_GDB: rdata = {16'h0000, gdb};
      `DFP_ADDR_FILT: rdata = {19'h0, filt};
      `DFP_ADDR_PG2: rdata = {16'h0000, pg2};
      `DFP_ADDR_LOAD_CUM: rdata = load_cum;
      `DFP_ADDR_MOT_CUM: rdata = mot_cum;
      `DFP_ADDR_GEARED: rdata = geared;
      `DFP_ADDR_LOAD_INFO: rdata = load_info;
      `DFP_ADDR_FBK: rdata = pos_feedback;
      `DFP_ADDR_STATUS: rdata = {27'h0, mark_seen, home_err,
                                 home_done, hstate};
      `DFP_ADDR_HOME: rdata = home_pos;
      default: rdata = 32'h00000000;
    endcase
  end

  // Pin synchronisers; stage 0 is read only by stage 1
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_a <= 3'h0;
      ls_b <= 3'h0;
      ls_m <= 3'h0;
      ms_a <= 3'h0;
      ms_b <= 3'h0;
      ds <= 2'h0;
    end else if (clk_en) begin
      ls_a <= {ls_a[1:0], load_a};
      ls_b <= {ls_b[1:0], load_b};
      ls_m <= {ls_m[1:0], load_mark};
      ms_a <= {ms_a[1:0], mot_a};
      ms_b <= {ms_b[1:0], mot_b};
      ds <= {ds[0], dog};
    end
  end

  // APB slave: no wait state, pready high in the first access cycle, read data latched in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (rd)
        prdata <= hit ? rdata : 32'h00000000;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= 1'b0;
      pol <= 1'b0;
      gna <= `DFP_GEAR_RESET;
      gnb <= `DFP_GEAR_RESET;
      gda <= `DFP_GEAR_RESET;
      gdb <= `DFP_GEAR_RESET;
      filt <= `DFP_FILT_RESET;
      pg2 <= `DFP_PG2_RESET;
      load_cum <= 32'h00000000;
      mot_cum <= 32'h00000000;
      load_info <= 32'h00000000;
      pos_feedback <= 32'h00000000;
    end else if (clk_en) begin
      if (wr && paddr == `DFP_ADDR_CTRL) begin
        mode <= pwdata[`DFP_CTRL_MODE];
        pol <= pwdata[`DFP_CTRL_POL];
      end
      if (wr && paddr == `DFP_ADDR_GNA)
        gna <= pwdata[15:0];
      if (wr && paddr == `DFP_ADDR_GNB)
        gnb <= pwdata[15:0];
      if (wr && paddr == `DFP_ADDR_GDA)
        gda <= pwdata[15:0];
      if (wr && paddr == `DFP_ADDR_GDB)
        gdb <= pwdata[15:0];
      if (wr && paddr == `DFP_ADDR_FILT)
        filt <= wfilt;
      if (wr && paddr == `DFP_ADDR_PG2)
        pg2 <= pwdata[15:0];
      // Count clear is a write action; a same-cycle step is kept
      if (wr && paddr == `DFP_ADDR_CTRL && pwdata[`DFP_CTRL_CLR_CUM]) begin
        load_cum <= step_cnt(32'h00000000, mode ? {ld_step[1],
                             ld_step[0] ^ pol} : 2'b00);
        mot_cum <= step_cnt(32'h00000000, md_step);
      end else begin
        if (mode)
          load_cum <= step_cnt(load_cum, {ld_step[1],
                                          ld_step[0] ^ pol});
        mot_cum <= step_cnt(mot_cum, md_step);
      end
      if (mark_rise)
        load_info <= 32'h00000000;
      else
        load_info <= step_cnt(load_info, {ld_step[1], ld_step[0] ^ pol});
      pos_feedback <= blend;
    end
  end

  // Home return on load-side mark only; motor Z-phase plays no part
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hstate <= H_IDLE;
      mark_seen <= 1'b0;
      dog_prev <= 1'b0;
      home_done <= 1'b0;
      home_err <= 1'b0;
      home_pos <= 32'h00000000;
    end else if (clk_en) begin
      dog_prev <= ds[1];
      case (hstate)
        H_IDLE: begin
          if (wr && paddr == `DFP_ADDR_CTRL &&
              pwdata[`DFP_CTRL_HOME_START]) begin
            hstate <= H_RUN;
            mark_seen <= 1'b0;
            home_done <= 1'b0;
            home_err <= 1'b0;
          end
        end
        H_RUN: begin
          if (mark_rise)
            mark_seen <= 1'b1;
          if (dog_prev && !ds[1]) begin
            if (mark_seen || mark_rise)
              hstate <= H_DOGOFF;
            else begin
              home_err <= 1'b1;
              hstate <= H_IDLE;
            end
          end
        end
        H_DOGOFF: begin
          if (mark_rise) begin
            home_pos <= load_cum;
            home_done <= 1'b1;
            hstate <= H_IDLE;
          end
        end
        default: hstate <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* tb/dfp_enc_model.sv */
// Quadrature encoder model with reference mark output
`timescale 1ns/10ps
`default_nettype none
module dfp_enc_model (
  input wire logic clk, // Sampling clock
  output logic a, // Phase A
  output logic b, // Phase B
  output logic z // Reference mark
);
  logic [1:0] s = 2'h0;
  assign a = s[1];
  assign b = s[1] ^ s[0];
  logic zr = 1'b0;
  assign z = zr;
  // Gray steps, slow enough for the two-stage synchroniser
  task mv(input int n);
    repeat (n < 0 ? -n : n) begin
      @(posedge clk);
      s <= (n < 0) ? s - 2'h1 : s + 2'h1;
      repeat (3) @(posedge clk);
    end
  endtask
  task mark();
    @(posedge clk);
    zr <= 1'b1;
    repeat (4) @(posedge clk);
    zr <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/dfp_checker.sv */
// Protocol and behaviour assertions for the feedback unit
`timescale 1ns/10ps
`default_nettype none
module dfp_checker (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic clk_en, // Enable
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic dog, // Dog
  input wire logic home_done, // Home done
  input wire logic home_err // Home error
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_bad;
    s_setup ##0 (paddr > 12'h034 || paddr[1:0] != 2'h0);
  endsequence
  property p_ack; s_setup |=> pready; endproperty
  property p_one; pready && clk_en |=> !pready; endproperty
  property p_acc; pready |-> psel && penable; endproperty
  property p_err; s_bad |=> pslverr; endproperty
  property p_ok;
    s_setup ##0 (paddr <= 12'h034 && paddr[1:0] == 2'h0) |=> !pslverr;
  endproperty
  property p_rdz; s_bad ##0 !pwrite |=> prdata == 32'h0; endproperty
  property p_filt;
    s_setup ##0 (!pwrite && paddr == 12'h014) |=> prdata <= 32'h1194;
  endproperty
  property p_home;
    s_setup ##0 (pwrite && paddr == 12'h0 && pwdata[2]) ##1 clk_en
      |=> !home_done;
  endproperty
  property p_herr; $rose(home_err) |-> !dog; endproperty
  a_ack: assert property (p_ack) else $error("no ready after setup");
  a_one: assert property (p_one) else $error("ready held too long");
  a_acc: assert property (p_acc) else $error("ready outside access");
  a_err: assert property (p_err) else $error("no error on bad address");
  a_ok: assert property (p_ok) else $error("error on mapped address");
  a_rdz: assert property (p_rdz) else $error("bad read not zero");
  a_filt: assert property (p_filt) else $error("filter above limit");
  a_home: assert property (p_home) else $error("home not restarted");
  a_herr: assert property (p_herr) else $error("home error on dog");
endmodule
bind dfp_unit dfp_checker i_chk (.pclk, .presetn, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dog, .home_done,
  .home_err);
`default_nettype wire

/* tb/dual_feedback_position_unit_tb.sv */
// Self-checking bench for the dual feedback position unit
`timescale 1ns/10ps
`default_nettype none
module dual_feedback_position_unit_tb;
  logic pclk = 1'b0;
  logic presetn, ce, psel, penable, pwrite, dog;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, fb, rd, v, m;
  logic pready, pslverr, home_done, home_err, la, lb, lz, ma, mb, mz, er;
  int err_total = 0, check_count = 0;
  always #50 pclk = ~pclk;
  dfp_enc_model i_ld (.clk(pclk), .a(la), .b(lb), .z(lz));
  dfp_enc_model i_mt (.clk(pclk), .a(ma), .b(mb), .z(mz));
  dfp_unit i_dut (.pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .load_a(la), .load_b(lb), .load_mark(lz), .mot_a(ma), .mot_b(mb),
    .dog(dog), .pos_feedback(fb), .home_done(home_done),
    .home_err(home_err));
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, s, e);
      err_total++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task t_regs();
    logic [11:0] ad [7] = '{12'h0, 12'h4, 12'h8, 12'hC, 12'h10, 12'h14, 12'h18};
    logic [31:0] ex [7] = '{0, 1, 1, 1, 1, 32'h000A, 0};
    foreach (ad[i]) rdc(ad[i], ex[i]);
    apb(1, 12'h18, 32'h2400);
    rdc(12'h18, 32'h2400);
    apb(1, 12'h14, 32'h1388);
    rdc(12'h14, 32'h1194);
    apb(1, 12'h38, 32'h5);
    chk({31'h0, er}, 1);
    rdc(12'h38, 0);
    chk({31'h0, er}, 1);
  endtask
  task t_load();
    apb(1, 12'h0, 32'h9);
    i_ld.mv(6);
    repeat (8) @(posedge pclk);
    apb(0, 12'h1C, 0);
    v = rd;
    chk(v * v, 32'h24);
    rdc(12'h28, v);
    i_ld.mark();
    repeat (8) @(posedge pclk);
    rdc(12'h28, 0);
    apb(1, 12'h0, 32'hB);
    i_ld.mv(6);
    repeat (8) @(posedge pclk);
    rdc(12'h1C, -v);
  endtask
  task t_gear();
    apb(1, 12'h4, 32'h3);
    apb(1, 12'h10, 32'h2);
    apb(1, 12'h0, 32'h9);
    i_mt.mv(4);
    i_ld.mv(6);
    repeat (8) @(posedge pclk);
    apb(0, 12'h20, 0);
    m = rd;
    chk(m * m, 32'h10);
    rdc(12'h24, $signed(m) * 3 / 2);
    rdc(12'h1C, $signed(m) * 3 / 2);
    i_ld.mv(2);
    repeat (8) @(posedge pclk);
    apb(0, 12'h1C, 0);
    v = rd;
    apb(1, 12'h14, 32'h0);
    rdc(12'h2C, $signed(m) * 3 / 2);
    apb(1, 12'h14, 32'h1194);
    rdc(12'h2C, v);
    apb(1, 12'h14, 32'h8CA);
    rdc(12'h2C, ($signed(m) * 3 / 2 + $signed(v)) / 2);
    apb(1, 12'h0, 32'h0);
    rdc(12'h2C, $signed(m) * 3 / 2);
  endtask
  task t_freeze();
    apb(1, 12'h14, 32'h1194);
    apb(1, 12'h0, 32'h1);
    repeat (2) @(posedge pclk);
    chk(fb, v);
    ce <= 1'b0;
    i_ld.mv(1);
    repeat (4) @(posedge pclk);
    chk(fb, v);
    ce <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(fb, v + 1);
  endtask
  task t_home();
    apb(1, 12'h0, 32'h5);
    dog <= 1;
    i_ld.mv(3);
    dog <= 0;
    repeat (8) @(posedge pclk);
    chk({31'h0, home_err}, 1);
    apb(1, 12'h0, 32'hD);
    dog <= 1;
    i_ld.mark();
    i_mt.mv(2);
    dog <= 0;
    i_ld.mv(2);
    repeat (4) @(posedge pclk);
    chk({31'h0, home_done}, 0);
    i_ld.mark();
    repeat (8) @(posedge pclk);
    chk({31'h0, home_done}, 1);
    rdc(12'h34, 32'h2);
    rdc(12'h1C, 32'h2);
  endtask
  task t_rst();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h14, 32'h000A);
    chk(fb, 0);
  endtask
  task end_of_test();
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    presetn <= 1'b0;
    ce <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    dog <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h00000000;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_load();
    t_gear();
    t_freeze();
    t_home();
    t_rst();
    end_of_test();
  end
  initial begin
    #2000000;
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
